/* src/qspi_flash_if.sv */
// serial flash interface: opcode decode, lane control, pause, write gating
`timescale 1ns/1ps
module qspi_flash_if #(
  parameter int PUW_CYC  = qspi_pkg::TPUW_CYC,
  parameter int BUSY_CYC = qspi_pkg::BUSY_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset,
  // link pins, asynchronous to mclk
  input  wire logic        sclk,
  input  wire logic        cs_n,
  input  wire logic [3:0]  lane_in,
  output logic      [3:0]  lane_out,
  output logic      [3:0]  lane_oe,
  // device state
  output logic             busy,
  output logic             write_enable_latch,
  output logic             quad_enable_bit,
  output logic             powered_down,
  output logic             suspended,
  output logic      [15:0] status_word
);
  import qspi_pkg::*;

  localparam logic [19:0] PUW_LD  = 20'(PUW_CYC);
  localparam logic [15:0] BUSY_LD = 16'(BUSY_CYC);

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic [5:0]  pin_s;
  logic [3:0]  lane_s;
  logic        cs_s;
  logic        sclk_s;
  logic        sclk_d;
  logic        cs_d;
  logic        armed_r;
  logic        sel;
  logic        cs_rise;
  logic        hold_r;
  logic        hold_ok;
  logic        rise_ok;
  logic        fall_ok;
  phase_t      phase_r;
  phase_t      ph_dec;
  logic [5:0]  cnt_r;
  logic [5:0]  cnt_inc;
  logic [7:0]  op_r;
  logic [7:0]  op_nxt;
  logic [23:0] addr_r;
  logic [15:0] wdat_r;
  logic [4:0]  wcnt_r;
  logic [2:0]  iw;
  logic [2:0]  ow;
  logic [2:0]  ocnt_r;
  logic [7:0]  sh_r;
  logic [7:0]  cur;
  logic [7:0]  src;
  logic        opc_done;
  logic [19:0] puw_cnt_r;
  logic        lock;
  logic [15:0] busy_cnt_r;
  logic        sr_job_r;
  logic [15:0] pend_r;
  logic [15:0] nv_r;
  logic        wel_r;
  logic        pd_r;
  logic        sus_r;
  logic        done;
  logic        may_write;
  logic        start_op;
  logic        start_sr;
  logic        sr_locked;
  logic        addr_prot;
  logic        any_prot;

  function automatic logic [2:0] out_width(input logic [7:0] op);
    if (op == OP_DOUT || op == OP_DIO) begin
      out_width = 3'h2;
    end else if (op == OP_QOUT || op == OP_QIO || op == OP_WQIO || op == OP_OQIO) begin
      out_width = 3'h4;
    end else begin
      out_width = 3'h1;
    end
  endfunction

  function automatic logic [2:0] in_width(input logic [7:0] op);
    if (op == OP_DIO) begin
      in_width = 3'h2;
    end else if (op == OP_QIO || op == OP_WQIO || op == OP_OQIO) begin
      in_width = 3'h4;
    end else begin
      in_width = 3'h1;
    end
  endfunction

  function automatic logic [5:0] dummy_len(input logic [7:0] op);
    unique case (op)
      OP_DOUT: dummy_len = DUMMY_DOUT;
      OP_DIO:  dummy_len = DUMMY_DIO;
      OP_QOUT: dummy_len = DUMMY_QOUT;
      OP_QIO:  dummy_len = DUMMY_QIO;
      OP_WQIO: dummy_len = DUMMY_WQIO;
      default: dummy_len = DUMMY_OQIO;
    endcase
  endfunction

  // the link clock is just another pin: sampled, then edge-detected
  sync2 #(.W(6)) u_sync (
    .clk   (mclk),
    .reset (reset),
    .d     ({cs_n, sclk, lane_in}),
    .q     (pin_s)
  );
  assign {cs_s, sclk_s, lane_s} = pin_s;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sclk_d <= 1'b0;
      cs_d   <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      cs_d   <= cs_s;
    end
  end

  // nothing is selected until cs has been seen high once
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      armed_r <= 1'b0;
    end else if (cs_s) begin
      armed_r <= 1'b1;
    end
  end

  assign sel     = armed_r & ~cs_s;
  assign cs_rise = armed_r & cs_s & ~cs_d;

  // mode 0 and mode 3 both sample on rise; the idle level never matters
  assign rise_ok = sel & ~hold_r & sclk_s & ~sclk_d;
  assign fall_ok = sel & ~hold_r & ~sclk_s & sclk_d;

  // pause follows the pin only while sclk is low, so a change made with
  // sclk high waits for the next falling edge
  assign hold_ok = sel & ~nv_r[BIT_QE] & ~((phase_r != PH_OPC) && (out_width(op_r) == 3'h4));

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hold_r <= 1'b0;
    end else if (!hold_ok) begin
      hold_r <= 1'b0;
    end else if (!sclk_s) begin
      hold_r <= ~lane_s[3];
    end
  end

  assign op_nxt   = {op_r[6:0], lane_s[0]};
  assign opc_done = rise_ok && (phase_r == PH_OPC) && (cnt_r == 6'h07);
  assign iw       = in_width(op_r);
  assign ow       = out_width(op_r);
  assign cnt_inc  = cnt_r + {3'h0, iw};

  always_comb begin
    ph_dec = PH_DONE;
    if (pd_r && op_nxt != OP_RDP) begin
      ph_dec = PH_SKIP;
    end else if (busy && op_nxt != OP_RDSR1 && op_nxt != OP_RDSR2 && op_nxt != OP_SUSP) begin
      ph_dec = PH_SKIP;
    end else if (!nv_r[BIT_QE] && out_width(op_nxt) == 3'h4) begin
      ph_dec = PH_SKIP;
    end else begin
      case (op_nxt)
        OP_RDSR1, OP_RDSR2:               ph_dec = PH_DOUT;
        OP_DOUT, OP_DIO:                  ph_dec = PH_ADDR;
        OP_QOUT, OP_QIO, OP_WQIO, OP_OQIO: ph_dec = PH_ADDR;
        OP_PP, OP_SE, OP_BE32, OP_BE64:   ph_dec = PH_ADDR;
        OP_WRSR:                          ph_dec = PH_DIN;
        default:                          ph_dec = PH_DONE;
      endcase
    end
  end

  // a paused transfer keeps every register here untouched; cs rising
  // during the pause still ends the frame and runs a complete instruction
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      phase_r <= PH_OPC;
      cnt_r   <= 6'h00;
      op_r    <= 8'h00;
      addr_r  <= 24'h000000;
      wdat_r  <= 16'h0000;
      wcnt_r  <= 5'h00;
    end else if (!sel) begin
      phase_r <= PH_OPC;
      cnt_r   <= 6'h00;
      wcnt_r  <= 5'h00;
    end else if (rise_ok) begin
      unique case (phase_r)
        PH_OPC: begin
          op_r  <= op_nxt;
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r == 6'h07) begin
            cnt_r   <= 6'h00;
            phase_r <= ph_dec;
          end
        end
        PH_ADDR: begin
          // wider lanes carry the high bit on the highest lane
          unique case (iw)
            3'h2:    addr_r <= {addr_r[21:0], lane_s[1:0]};
            3'h4:    addr_r <= {addr_r[19:0], lane_s};
            default: addr_r <= {addr_r[22:0], lane_s[0]};
          endcase
          cnt_r <= cnt_inc;
          if (cnt_inc == ADDR_BITS) begin
            cnt_r   <= 6'h00;
            phase_r <= (op_r == OP_PP || op_r == OP_SE || op_r == OP_BE32 || op_r == OP_BE64)
                       ? PH_DIN : PH_DUMMY;
          end
        end
        PH_DUMMY: begin
          cnt_r <= cnt_r + 6'h01;
          if (cnt_r + 6'h01 == dummy_len(op_r)) begin
            phase_r <= PH_DOUT;
          end
        end
        PH_DIN: begin
          wdat_r <= {wdat_r[14:0], lane_s[0]};
          if (wcnt_r != 5'h1F) begin
            wcnt_r <= wcnt_r + 5'h01;
          end
        end
        PH_DONE: phase_r <= PH_SKIP;
        PH_DOUT, PH_SKIP: ;
      endcase
    end
  end

  always_comb begin
    src = FILL_BYTE;
    if (op_r == OP_RDSR1) begin
      src = status_word[7:0];
    end else if (op_r == OP_RDSR2) begin
      src = status_word[15:8];
    end
    cur = (ocnt_r == 3'h0) ? src : sh_r;
  end

  // status is re-read at each byte boundary so a busy poll sees it clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ocnt_r   <= 3'h0;
      sh_r     <= 8'h00;
      lane_out <= 4'h0;
    end else if (!sel || phase_r != PH_DOUT) begin
      ocnt_r <= 3'h0;
    end else if (fall_ok) begin
      sh_r   <= cur << ow;
      ocnt_r <= ocnt_r + ow;
      unique case (ow)
        3'h2:    lane_out <= {2'h0, cur[7:6]};
        3'h4:    lane_out <= cur[7:4];
        default: lane_out <= {2'h0, cur[7], 1'b0};
      endcase
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      lane_oe <= 4'h0;
    end else if (sel && !hold_r && phase_r == PH_DOUT) begin
      lane_oe <= (ow == 3'h4) ? 4'hF : ((ow == 3'h2) ? 4'h3 : 4'h2);
    end else begin
      lane_oe <= 4'h0;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      puw_cnt_r <= PUW_LD;
    end else if (puw_cnt_r != 20'h00000) begin
      puw_cnt_r <= puw_cnt_r - 20'h00001;
    end
  end
  assign lock = (puw_cnt_r != 20'h00000);

  write_guard u_guard (
    .nv        (nv_r),
    .wp_n      (lane_s[2]),
    .addr      (addr_r),
    .sr_locked (sr_locked),
    .addr_prot (addr_prot),
    .any_prot  (any_prot)
  );

  assign may_write = wel_r & ~lock & (busy_cnt_r == 16'h0000);

  always_comb begin
    start_op = 1'b0;
    start_sr = 1'b0;
    if (cs_rise && may_write) begin
      if (phase_r == PH_DONE && (op_r == OP_CE || op_r == OP_CE2)) begin
        start_op = ~any_prot;
      end
      if (phase_r == PH_DIN &&
          (op_r == OP_PP || op_r == OP_SE || op_r == OP_BE32 || op_r == OP_BE64)) begin
        start_op = ~addr_prot;
      end
      if (phase_r == PH_DIN && op_r == OP_WRSR && (wcnt_r == 5'h08 || wcnt_r == 5'h10)) begin
        start_sr = ~sr_locked;
      end
    end
  end

  assign done = (busy_cnt_r == 16'h0001) & ~sus_r;

  // a write is a timed busy period; its effect lands when the count ends
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      busy_cnt_r <= 16'h0000;
      sr_job_r   <= 1'b0;
      pend_r     <= NV_RST;
      nv_r       <= NV_RST;
      wel_r      <= 1'b0;
      pd_r       <= 1'b0;
      sus_r      <= 1'b0;
    end else begin
      if (busy_cnt_r != 16'h0000 && !sus_r) begin
        busy_cnt_r <= busy_cnt_r - 16'h0001;
      end
      if (done) begin
        wel_r <= 1'b0;
        if (sr_job_r) begin
          nv_r <= pend_r & WR_MASK;
        end
      end
      if (start_op || start_sr) begin
        busy_cnt_r <= BUSY_LD;
        sr_job_r   <= start_sr;
        pend_r     <= (wcnt_r == 5'h08) ? {nv_r[15:8], wdat_r[7:0]}
                                        : {wdat_r[7:0], wdat_r[15:8]};
      end
      if (cs_rise && phase_r == PH_DONE) begin
        case (op_r)
          OP_WREN: wel_r <= ~lock;
          OP_WRDI: wel_r <= 1'b0;
          OP_PD:   pd_r  <= 1'b1;
          OP_RDP:  pd_r  <= 1'b0;
          OP_SUSP: sus_r <= (busy_cnt_r != 16'h0000) & ~sr_job_r;
          OP_RESM: sus_r <= 1'b0;
          default: ;
        endcase
      end
    end
  end

  assign busy = (busy_cnt_r != 16'h0000) & ~sus_r;

  always_comb begin
    status_word           = nv_r & WR_MASK;
    status_word[BIT_BUSY] = busy;
    status_word[BIT_WEL]  = wel_r;
    status_word[BIT_SUS]  = sus_r;
  end

  assign write_enable_latch = wel_r;
  assign quad_enable_bit    = nv_r[BIT_QE];
  assign powered_down       = pd_r;
  assign suspended          = sus_r;

  sequence s_pd_cmd;
    opc_done && pd_r && op_nxt != OP_RDP;
  endsequence
  sequence s_busy_cmd;
    opc_done && busy && op_nxt == OP_WREN;
  endsequence

  property p_desel;
    cs_s |=> lane_oe == 4'h0;
  endproperty
  a_desel: assert property (p_desel) else $error("lanes driven while deselected");
  property p_arm;
    !armed_r |=> phase_r == PH_OPC;
  endproperty
  a_arm: assert property (p_arm) else $error("instruction before first cs fall");
  property p_quad;
    opc_done && !nv_r[BIT_QE] && out_width(op_nxt) == 3'h4 |=> phase_r == PH_SKIP;
  endproperty
  a_quad: assert property (p_quad) else $error("quad opcode run without enable");
  property p_out_edge;
    lane_out != $past(lane_out) |-> $past(fall_ok);
  endproperty
  a_out_edge: assert property (p_out_edge) else $error("output changed off falling edge");
  property p_hold_float;
    hold_r |=> lane_oe == 4'h0;
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("output driven in pause");
  property p_hold_start;
    hold_ok && !lane_s[3] && !sclk_s |=> hold_r;
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("pause did not start");
  property p_hold_end;
    hold_r && lane_s[3] && !sclk_s |=> !hold_r;
  endproperty
  a_hold_end: assert property (p_hold_end) else $error("pause did not end");
  property p_hold_qe;
    nv_r[BIT_QE] |=> !hold_r;
  endproperty
  a_hold_qe: assert property (p_hold_qe) else $error("pause active with quad enable");
  property p_puw;
    lock && cs_rise && phase_r == PH_DONE && op_r == OP_WREN |=> !wel_r;
  endproperty
  a_puw: assert property (p_puw) else $error("write enable taken in power-up delay");
  property p_wel_done;
    done |=> !wel_r ##1 !busy;
  endproperty
  a_wel_done: assert property (p_wel_done) else $error("latch kept after write");
  property p_pd;
    s_pd_cmd |=> phase_r == PH_SKIP;
  endproperty
  a_pd: assert property (p_pd) else $error("instruction taken in power-down");
  property p_wrsr_lock;
    sr_locked && cs_rise && op_r == OP_WRSR |-> !start_sr;
  endproperty
  a_wrsr_lock: assert property (p_wrsr_lock) else $error("locked status written");
  property p_busy;
    s_busy_cmd |=> phase_r == PH_SKIP;
  endproperty
  a_busy: assert property (p_busy) else $error("instruction taken while busy");
endmodule

/* src/qspi_pkg.sv */
// shared constants and types for the serial flash host interface
package qspi_pkg;
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_WRSR  = 8'h01;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE32  = 8'h52;
  localparam logic [7:0] OP_BE64  = 8'hD8;
  localparam logic [7:0] OP_CE    = 8'hC7;
  localparam logic [7:0] OP_CE2   = 8'h60;
  localparam logic [7:0] OP_SUSP  = 8'h75;
  localparam logic [7:0] OP_RESM  = 8'h7A;
  localparam logic [7:0] OP_PD    = 8'hB9;
  localparam logic [7:0] OP_RDP   = 8'hAB;
  localparam logic [7:0] OP_DOUT  = 8'h3B;
  localparam logic [7:0] OP_DIO   = 8'hBB;
  localparam logic [7:0] OP_QOUT  = 8'h6B;
  localparam logic [7:0] OP_QIO   = 8'hEB;
  localparam logic [7:0] OP_WQIO  = 8'hE7;
  localparam logic [7:0] OP_OQIO  = 8'hE3;
  localparam logic [5:0] DUMMY_DOUT = 6'h08;
  localparam logic [5:0] DUMMY_DIO  = 6'h04;
  localparam logic [5:0] DUMMY_QOUT = 6'h08;
  localparam logic [5:0] DUMMY_QIO  = 6'h06;
  localparam logic [5:0] DUMMY_WQIO = 6'h04;
  localparam logic [5:0] DUMMY_OQIO = 6'h02;
  localparam logic [5:0] ADDR_BITS  = 6'h18;
  localparam int BIT_BUSY = 0;
  localparam int BIT_WEL  = 1;
  localparam int BIT_BP0  = 2;
  localparam int BIT_TB   = 5;
  localparam int BIT_SEC  = 6;
  localparam int BIT_STATUS_PROTECT_LO = 7;
  localparam int BIT_STATUS_PROTECT_HI = 8;
  localparam int BIT_QE   = 9;
  localparam int BIT_SUS  = 15;
  localparam logic [15:0] NV_RST   = 16'h0000;
  localparam logic [15:0] WR_MASK  = 16'h03FC;
  localparam logic [7:0]  FILL_BYTE = 8'hFF;
  localparam int CLK_MHZ  = 25;
  localparam int TPUW_US  = 1000;
  localparam int TPUW_CYC = TPUW_US * CLK_MHZ;
  localparam int BUSY_NS  = 2560;
  localparam int BUSY_CYC = (BUSY_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [2:0] {PH_OPC, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_DONE, PH_SKIP} phase_t;
endpackage

/* src/sync2.sv */
// two-stage synchroniser for link pins
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule

/* src/write_guard.sv */
// status-write lock and array protection decode
`timescale 1ns/1ps
module write_guard (
  // status bits and protect pin
  input  wire logic [15:0] nv,
  input  wire logic        wp_n,
  // target address
  input  wire logic [23:0] addr,
  // decisions
  output logic             sr_locked,
  output logic             addr_prot,
  output logic             any_prot
);
  import qspi_pkg::*;

  logic [2:0]  bp;
  logic [20:0] span;
  logic        all;

  // pin protect has no meaning once the pin carries quad data
  assign sr_locked = nv[BIT_STATUS_PROTECT_HI] | (nv[BIT_STATUS_PROTECT_LO] & ~wp_n & ~nv[BIT_QE]);
  assign bp        = nv[BIT_BP0+2:BIT_BP0];
  assign any_prot  = (bp != 3'h0);
  assign all       = (bp[2:1] == 2'h3);

  always_comb begin
    span = 21'h0;
    if (any_prot) begin
      span = nv[BIT_SEC] ? (21'h001000 << (bp - 3'h1)) : (21'h010000 << (bp - 3'h1));
    end
    // top region is the last span bytes, bottom the first
    addr_prot = all | (any_prot & (nv[BIT_TB] ? (addr[20:0] < span)
                                              : (addr[20:0] >= (21'h0 - span))));
  end
endmodule

/* test/spi_master_model.sv */
// spi bus master model that drives the serial flash link
`timescale 1ns/1ps
module spi_master_model (
  // link to the device
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] lane_in,
  input  wire logic [3:0] lane_out,
  input  wire logic [3:0] lane_oe
);
  logic [3:0] m_val;
  logic       hold_n;
  logic       wp_lvl;
  logic       mode3;
  logic [3:0] cap;
  logic [3:0] po_a;
  logic [3:0] po_b;
  logic [3:0] end_oe;

  // released lanes 0/1 show the inverse of their last level, 2/3 carry the wp_lvl and hold_n levels
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & m_val);

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    m_val = 4'hC;
    hold_n = 1'b1;
    wp_lvl = 1'b1;
    mode3 = 1'b0;
  end

  // data moves while sclk is low so the device sees it settled at the rise
  task automatic one_clk(input logic [3:0] v, input logic [3:0] en, input logic p);
    sclk = 1'b0;
    m_val[1:0] = (v[1:0] & en[1:0]) | (~m_val[1:0] & ~en[1:0]);
    m_val[2] = en[2] ? v[2] : wp_lvl;
    m_val[3] = en[3] ? v[3] : hold_n;
    #160;
    if (p) begin
      // pause with sclk low; cs stays low, and a stray clock pulse must be ignored
      hold_n = 1'b0;
      m_val[3] = 1'b0;
      #320;
      po_a = lane_oe;
      sclk = 1'b1;
      #160;
      sclk = 1'b0;
      #160;
      hold_n = 1'b1;
      m_val[3] = 1'b1;
      #320;
      po_b = lane_oe;
    end
    sclk = 1'b1;
    #150;
    cap = lane_in;
    #10;
  endtask

  // opcode msb first on lane 0 after cs falls, then address, dummy, read clocks
  task automatic frame(input logic [7:0] op, input logic [31:0] ad, input int ac,
                       input int aw, input int dm, input int rc, input int rw,
                       input int pz, output logic [7:0] rd);
    logic [3:0] msk;
    msk = 4'((1 << aw) - 1);
    rd = 8'h00;
    sclk = mode3; // idle level at both cs edges picks mode 0 or 3
    #160;
    cs_n = 1'b0;
    #160;
    for (int k = 0; k < 8; k++) one_clk({3'b000, op[7-k]}, 4'h1, 1'b0);
    for (int k = 0; k < ac; k++) one_clk(4'(ad >> ((ac - 1 - k) * aw)) & msk, msk, 1'b0);
    for (int k = 0; k < dm; k++) one_clk(4'h0, 4'h0, 1'b0);
    for (int k = 0; k < rc; k++) begin
      one_clk(4'h0, 4'h0, 1'(k == pz));
      rd = 8'((rd << rw) | (rw == 1 ? {3'b000, cap[1]} : cap & 4'((1 << rw) - 1)));
    end
    end_oe = lane_oe;
    sclk = mode3;
    #160;
    cs_n = 1'b1;
    #200;
  endtask
endmodule

/* test/tb_top.sv */
// self-checking bench for the serial flash interface
`timescale 1ns/1ps
module tb_top;
  import qspi_pkg::*;
  typedef struct {
    logic [7:0] op;
    int         ac;
    int         aw;
    int         dm;
    int         rc;
    int         rw;
    int         m3;
    int         pz;
    logic [3:0] oe;
    logic [7:0] d;
  } row_t;
  logic        mclk;
  logic        reset;
  logic        sclk;
  logic        cs_n;
  logic [3:0]  lane_in;
  logic [3:0]  lane_out;
  logic [3:0]  lane_oe;
  logic        busy;
  logic        write_enable_latch;
  logic        quad_enable_bit;
  logic        powered_down;
  logic        suspended;
  logic [15:0] status_word;
  logic [7:0]  rd;
  int          errors;
  int          checked;
  int          cyc;
  row_t        rows [9];

  qspi_flash_if #(.PUW_CYC(200), .BUSY_CYC(400)) uut (
    .mclk(mclk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .lane_in(lane_in),
    .lane_out(lane_out), .lane_oe(lane_oe), .busy(busy),
    .write_enable_latch(write_enable_latch), .quad_enable_bit(quad_enable_bit),
    .powered_down(powered_down), .suspended(suspended), .status_word(status_word));

  spi_master_model pm (.sclk(sclk), .cs_n(cs_n), .lane_in(lane_in), .lane_out(lane_out),
                       .lane_oe(lane_oe));

  always #20 mclk = ~mclk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    if (errors == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op, input logic [31:0] ad, input int ac);
    pm.frame(op, ad, ac, 1, 0, 0, 1, -1, rd);
  endtask

  // bounded wait for a timed write to finish
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 500) begin
      @(negedge mclk);
      n++;
    end
    check({15'h0000, busy}, 16'h0000);
  endtask

  // ceiling sits well above the roughly 5800 cycles the sequence needs
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    errors = 0;
    checked = 0;
    cyc = 0;
    // quad rows are refused while quad enable is still clear
    rows = '{'{OP_RDSR1, 0, 1, 0, 8, 1, 0, -1, 4'h2, 8'h02},
             '{OP_RDSR1, 0, 1, 0, 8, 1, 1, 3, 4'h2, 8'h02},
             '{OP_RDSR2, 0, 1, 0, 8, 1, 0, -1, 4'h2, 8'h00},
             '{OP_DOUT, 24, 1, 8, 4, 2, 0, -1, 4'h3, 8'hFF},
             '{OP_DIO, 12, 2, 4, 4, 2, 0, -1, 4'h3, 8'hFF},
             '{OP_QOUT, 24, 1, 8, 2, 4, 0, -1, 4'h0, 8'h00},
             '{OP_QIO, 24, 1, 6, 2, 4, 0, -1, 4'h0, 8'h00},
             '{OP_WQIO, 24, 1, 4, 2, 4, 0, -1, 4'h0, 8'h00},
             '{OP_OQIO, 24, 1, 2, 2, 4, 0, -1, 4'h0, 8'h00}};
    repeat (3) @(negedge mclk);
    check(status_word, 16'h0000);
    check({12'h000, lane_oe}, 16'h0000);
    reset = 1'b0;
    cmd(OP_WREN, 32'h0, 0);
    check({15'h0000, write_enable_latch}, 16'h0000);
    repeat (200) @(negedge mclk);
    cmd(OP_WREN, 32'h0, 0);
    check(status_word, 16'h0002);
    foreach (rows[i]) begin
      pm.mode3 = rows[i].m3[0];
      pm.frame(rows[i].op, 32'h00123456, rows[i].ac, rows[i].aw, rows[i].dm,
               rows[i].rc, rows[i].rw, rows[i].pz, rd);
      check({12'h000, pm.end_oe}, {12'h000, rows[i].oe});
      if (rows[i].oe != 4'h0) begin
        check({8'h00, rd}, {8'h00, rows[i].d});
      end
      if (rows[i].pz >= 0) begin
        check({12'h000, pm.po_a}, 16'h0000);
        check({12'h000, pm.po_b}, {12'h000, rows[i].oe});
      end
      check({12'h000, lane_oe}, 16'h0000);
    end
    pm.mode3 = 1'b0;
    cmd(OP_WRSR, 32'h00000084, 8);
    check({15'h0000, busy}, 16'h0001);
    cmd(OP_WREN, 32'h0, 0);
    pm.frame(OP_RDSR1, 32'h0, 0, 1, 0, 8, 1, -1, rd);
    check({8'h00, rd}, 16'h0003);
    wait_idle();
    check(status_word, 16'h0084);
    cmd(OP_WREN, 32'h0, 0);
    pm.wp_lvl = 1'b0;
    cmd(OP_WRSR, 32'h00000000, 8);
    check({15'h0000, busy}, 16'h0000);
    check(status_word & 16'hFFFD, 16'h0084);
    // top 64 KB block is read-only while block protect is one
    cmd(OP_SE, 32'h001FF000, 24);
    check({15'h0000, busy}, 16'h0000);
    pm.wp_lvl = 1'b1;
    cmd(OP_WREN, 32'h0, 0);
    cmd(OP_WRSR, 32'h00000002, 16);
    wait_idle();
    check(status_word, 16'h0200);
    check({15'h0000, quad_enable_bit}, 16'h0001);
    // quad address puts zeros on lane 3, which must not pause the device
    pm.frame(OP_QIO, 32'h00123456, 6, 4, 6, 2, 4, -1, rd);
    check({12'h000, pm.end_oe}, 16'h000F);
    check({8'h00, rd}, 16'h00FF);
    cmd(OP_WREN, 32'h0, 0);
    cmd(OP_SE, 32'h001FF000, 24);
    check({15'h0000, busy}, 16'h0001);
    cmd(OP_SUSP, 32'h0, 0);
    check({14'h0000, suspended, busy}, 16'h0002);
    cmd(OP_RESM, 32'h0, 0);
    check({14'h0000, suspended, busy}, 16'h0001);
    wait_idle();
    check({15'h0000, write_enable_latch}, 16'h0000);
    cmd(OP_PD, 32'h0, 0);
    check({15'h0000, powered_down}, 16'h0001);
    cmd(OP_WREN, 32'h0, 0);
    check({15'h0000, write_enable_latch}, 16'h0000);
    cmd(OP_RDP, 32'h0, 0);
    check({15'h0000, powered_down}, 16'h0000);
    // a second power cycle must lock writes out again
    reset = 1'b1;
    repeat (3) @(negedge mclk);
    check(status_word, 16'h0000);
    reset = 1'b0;
    cmd(OP_WREN, 32'h0, 0);
    check({15'h0000, write_enable_latch}, 16'h0000);
    report_and_stop();
  end
endmodule
